// ### include/port_pkg.sv
// package: register map, field positions and carrier types for the two ports
package port_pkg;
  // register word addresses (byte offsets on a 32-bit wishbone)
  localparam logic [7:0] first_port_data_off = 8'h00;
  localparam logic [7:0] first_port_latch_off = 8'h04;
  localparam logic [7:0] first_port_direction_off = 8'h08;
  localparam logic [7:0] second_port_data_off = 8'h0C;
  localparam logic [7:0] second_port_latch_off = 8'h10;
  localparam logic [7:0] second_port_direction_off = 8'h14;
  localparam logic [7:0] memory_control_off = 8'h18;
  localparam logic [7:0] parallel_slave_control_off = 8'h1C;
  // field positions
  localparam int external_bus_disable_pos = 7;
  localparam int parallel_slave_mode_pos = 4;
  localparam int serial_pin6_pos = 6;
  localparam int serial_pin7_pos = 7;
  // reset values
  localparam logic [7:0] direction_reset = 8'hFF;
  localparam logic [7:0] latch_reset = 8'h00;
  localparam logic [7:0] memory_control_reset = 8'h00;
  localparam logic [7:0] parallel_slave_control_reset = 8'h00;

  // one 8-bit pin group: output value and output enable
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_t;

  // serial transceiver signals facing the first port
  typedef struct packed {
    logic enable;
    logic sync_mode;
    logic async_transmit_out;
    logic sync_clock_out;
    logic sync_clock_master;
    logic sync_data_out;
    logic sync_data_drive;
  } serial_side_t;

  // external memory bus and parallel slave port towards the second port
  typedef struct packed {
    logic [7:0] ext_bus_out;
    logic ext_bus_drive;
    logic [7:0] parallel_out;
    logic parallel_drive;
  } takeover_t;
endpackage : port_pkg

// ### logic/bidir_port_pin_override.sv
// module: two 8-bit bidirectional ports with serial and bus pin takeover
//
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module bidir_port_pin_override #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // first port pins
  input wire logic [7:0] first_pin_i,
  output logic [7:0] first_pin_o,
  output logic [7:0] first_pin_oe_o,
  // second port pins
  input wire logic [7:0] second_pin_i,
  output logic [7:0] second_pin_o,
  output logic [7:0] second_pin_oe_o,
  // serial transceiver side
  input wire port_pkg::serial_side_t serial_i,
  output logic async_receive_in_o,
  output logic sync_serial_data_o,
  output logic sync_serial_clock_o,
  // external bus and parallel slave side
  input wire port_pkg::takeover_t takeover_i,
  output logic external_bus_active_o,
  output logic parallel_slave_active_o,
  output logic [7:0] second_port_level_o
);

  // elaboration check: ports are byte wide
  if (WIDTH != 8)
  begin : g_width_check
    $error("WIDTH must be 8");
  end

  // elaboration check: serial pins must sit inside the port
  if (port_pkg::serial_pin6_pos >= WIDTH || port_pkg::serial_pin7_pos >= WIDTH)
  begin : g_serial_pos_check
    $error("serial pin positions outside the port");
  end

  // elaboration check: control fields must sit inside a byte register
  if (port_pkg::external_bus_disable_pos > 7 || port_pkg::parallel_slave_mode_pos > 7)
  begin : g_field_pos_check
    $error("control field positions outside the register");
  end

  // whole block state
  typedef struct packed {
    // first port input synchroniser and filtered level
    logic [7:0] first_sync1;
    logic [7:0] first_sync2;
    logic [7:0] first_sync3;
    logic [7:0] first_level;
    // second port input synchroniser and filtered level
    logic [7:0] second_sync1;
    logic [7:0] second_sync2;
    logic [7:0] second_sync3;
    logic [7:0] second_level;
    // software-visible registers
    logic [7:0] first_latch;
    logic [7:0] first_direction;
    logic [7:0] second_latch;
    logic [7:0] second_direction;
    logic [7:0] memory_control;
    logic [7:0] parallel_control;
    // bus answer
    logic ack;
    logic err;
    logic [31:0] rdata;
    // registered pin drive
    port_pkg::pin_drive_t first_drive;
    port_pkg::pin_drive_t second_drive;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // byte-lane merge for writes to an 8-bit register
  function automatic logic [7:0] lane_write(input logic [7:0] old, input logic [31:0] wd,
                                            input logic [3:0] sel);
    lane_write = sel[0] ? wd[7:0] : old;
  endfunction : lane_write

  // filtered level: a pin bit moves only when stages 2 and 3 agree
  function automatic logic [7:0] agree_filter(input logic [7:0] held, input logic [7:0] s2,
                                              input logic [7:0] s3);
    logic [7:0] result;
    result = held;
    for (int i = 0; i < 8; i++)
    begin
      if (s2[i] == s3[i])
      begin
        result[i] = s3[i];
      end
    end
    agree_filter = result;
  endfunction : agree_filter

  // next-state logic
  always_comb
  begin
    logic req;
    logic mapped;
    logic ext_on;
    logic psp_on;
    logic [7:0] f_out;
    logic [7:0] f_oe;
    // the answer cycle blocks a second take of the same request
    req = cyc_i && stb_i && !state_reg.ack && !state_reg.err;
    mapped = 1'b0;
    // scratch values start from a known level
    ext_on = 1'b0;
    psp_on = 1'b0;
    f_out = 8'h00;
    f_oe = 8'h00;
    state_next = state_reg;
    // three-stage pin synchronisers, level taken when stages 2 and 3 agree
    state_next.first_sync1 = first_pin_i;
    state_next.first_sync2 = state_reg.first_sync1;
    state_next.first_sync3 = state_reg.first_sync2;
    state_next.second_sync1 = second_pin_i;
    state_next.second_sync2 = state_reg.second_sync1;
    state_next.second_sync3 = state_reg.second_sync2;
    state_next.first_level = agree_filter(state_reg.first_level, state_reg.first_sync2,
                                          state_reg.first_sync3);
    state_next.second_level = agree_filter(state_reg.second_level, state_reg.second_sync2,
                                           state_reg.second_sync3);
    // bus answer lasts one cycle
    state_next.ack = 1'b0;
    state_next.err = 1'b0;
    state_next.rdata = 32'h0000_0000;
    if (req)
    begin
      mapped = 1'b1;
      unique case (adr_i)
        // pin levels read, writes load latch
        port_pkg::first_port_data_off:
        begin
          state_next.rdata[7:0] = state_reg.first_level;
          if (we_i)
          begin
            state_next.first_latch = lane_write(state_reg.first_latch, dat_i, sel_i);
          end
        end
        port_pkg::first_port_latch_off:
        begin
          state_next.rdata[7:0] = state_reg.first_latch;
          if (we_i)
          begin
            state_next.first_latch = lane_write(state_reg.first_latch, dat_i, sel_i);
          end
        end
        port_pkg::first_port_direction_off:
        begin
          state_next.rdata[7:0] = state_reg.first_direction;
          if (we_i)
          begin
            state_next.first_direction = lane_write(state_reg.first_direction, dat_i, sel_i);
          end
        end
        // second port pin levels read, writes load latch
        port_pkg::second_port_data_off:
        begin
          state_next.rdata[7:0] = state_reg.second_level;
          if (we_i)
          begin
            state_next.second_latch = lane_write(state_reg.second_latch, dat_i, sel_i);
          end
        end
        port_pkg::second_port_latch_off:
        begin
          state_next.rdata[7:0] = state_reg.second_latch;
          if (we_i)
          begin
            state_next.second_latch = lane_write(state_reg.second_latch, dat_i, sel_i);
          end
        end
        port_pkg::second_port_direction_off:
        begin
          state_next.rdata[7:0] = state_reg.second_direction;
          if (we_i)
          begin
            state_next.second_direction = lane_write(state_reg.second_direction, dat_i,
                                                     sel_i);
          end
        end
        port_pkg::memory_control_off:
        begin
          state_next.rdata[7:0] = state_reg.memory_control;
          if (we_i)
          begin
            state_next.memory_control = lane_write(state_reg.memory_control, dat_i, sel_i);
          end
        end
        port_pkg::parallel_slave_control_off:
        begin
          state_next.rdata[7:0] = state_reg.parallel_control;
          if (we_i)
          begin
            state_next.parallel_control = lane_write(state_reg.parallel_control, dat_i, sel_i);
          end
        end
        default:
        begin
          mapped = 1'b0;
        end
      endcase
      state_next.ack = mapped;
      state_next.err = !mapped;
    end

    // external bus owns the port unless disabled
    ext_on = !state_reg.memory_control[port_pkg::external_bus_disable_pos];
    psp_on = state_reg.parallel_control[port_pkg::parallel_slave_mode_pos];
    // eight pins, each driven or released on its own in port data mode; takeover drives or releases all eight together
    // takeover drive comes straight from the owning block, no latch
    // priority external bus, parallel port, port data
    if (ext_on)
    begin
      state_next.second_drive.out = takeover_i.ext_bus_out;
      state_next.second_drive.oe = {8{takeover_i.ext_bus_drive}};
    end
    else if (psp_on)
    begin
      state_next.second_drive.out = takeover_i.parallel_out;
      state_next.second_drive.oe = {8{takeover_i.parallel_drive}};
    end
    else
    begin
      // direction 1 releases driver; direction 0 drives latch
      state_next.second_drive.out = state_reg.second_latch;
      state_next.second_drive.oe = ~state_reg.second_direction;
    end

    // first port: latch by default, serial overrides on pins 6 and 7
    f_out = state_reg.first_latch;
    f_oe = ~state_reg.first_direction;
    if (serial_i.enable && !serial_i.sync_mode)
    begin
      // transmit data in place of latch on pin 6
      f_out[port_pkg::serial_pin6_pos] = serial_i.async_transmit_out;
    end
    if (serial_i.enable && serial_i.sync_mode)
    begin
      // clock driven at direction 0, input at direction 1
      f_out[port_pkg::serial_pin6_pos] = serial_i.sync_clock_out;
      // pin 7 driven by transceiver even with direction left at 1
      if (serial_i.sync_data_drive)
      begin
        f_out[port_pkg::serial_pin7_pos] = serial_i.sync_data_out;
        f_oe[port_pkg::serial_pin7_pos] = 1'b1;
      end
    end
    state_next.first_drive.out = f_out;
    state_next.first_drive.oe = f_oe;

    // reset wins over any bus write in the same cycle
    if (rst_i)
    begin
      state_next = '0;
      state_next.first_direction = port_pkg::direction_reset;
      state_next.second_direction = port_pkg::direction_reset;
      state_next.first_latch = port_pkg::latch_reset;
      state_next.second_latch = port_pkg::latch_reset;
      state_next.memory_control = port_pkg::memory_control_reset;
      state_next.parallel_control = port_pkg::parallel_slave_control_reset;
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    state_reg <= state_next;
  end

  // bus answer
  assign dat_o = state_reg.rdata;
  assign ack_o = state_reg.ack;
  assign err_o = state_reg.err;

  // first port pin drive
  assign first_pin_o = state_reg.first_drive.out;
  assign first_pin_oe_o = state_reg.first_drive.oe;

  // second port pin drive and filtered levels
  assign second_pin_o = state_reg.second_drive.out;
  assign second_pin_oe_o = state_reg.second_drive.oe;
  assign second_port_level_o = state_reg.second_level;

  // takeover status
  assign external_bus_active_o =
    !state_reg.memory_control[port_pkg::external_bus_disable_pos];
  assign parallel_slave_active_o =
    state_reg.parallel_control[port_pkg::parallel_slave_mode_pos] && !external_bus_active_o;

  // async receive from pin 7 while it is an input
  assign async_receive_in_o = state_reg.first_level[port_pkg::serial_pin7_pos] &&
    state_reg.first_direction[port_pkg::serial_pin7_pos];
  // sync data input from pin 7 level
  assign sync_serial_data_o = state_reg.first_level[port_pkg::serial_pin7_pos] &&
    state_reg.first_direction[port_pkg::serial_pin7_pos];
  // external clock taken when pin 6 is an input
  assign sync_serial_clock_o = state_reg.first_direction[port_pkg::serial_pin6_pos] ?
    state_reg.first_level[port_pkg::serial_pin6_pos] : serial_i.sync_clock_out;

endmodule : bidir_port_pin_override

`default_nettype wire

// ### tb/port_checker.sv
// checker: bus handshake and second port takeover properties
`timescale 1ns/1ps
`default_nettype none
module port_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic err_o,
  input wire logic [31:0] dat_o,
  // second port
  input wire logic [7:0] second_pin_o,
  input wire logic [7:0] second_pin_oe_o,
  input wire port_pkg::takeover_t takeover_i,
  input wire logic external_bus_active_o,
  input wire logic parallel_slave_active_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus answers
  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_err_one_cycle: assert property (err_o |=> !err_o)
    else $error("err held too long");
  a_req_answered: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o)
    else $error("request not answered");
  a_answer_cause: assert property (ack_o || err_o |-> $past(cyc_i && stb_i))
    else $error("answer without request");
  a_resp_exclusive: assert property (!(ack_o && err_o))
    else $error("ack and err together");
  a_dat_idle_zero: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  // external bus owns the pins
  a_ext_bus_drive: assert property (
    !$past(rst_i) && $past(external_bus_active_o) && $past(takeover_i.ext_bus_drive)
    |-> second_pin_o == $past(takeover_i.ext_bus_out) && second_pin_oe_o == 8'hFF)
    else $error("external bus not on pins");
  a_ext_bus_release: assert property (
    !$past(rst_i) && $past(external_bus_active_o) && !$past(takeover_i.ext_bus_drive)
    |-> second_pin_oe_o == 8'h00)
    else $error("pins driven while bus reads");
  // parallel port priority
  a_psp_yields: assert property (
    !$past(rst_i) && $past(parallel_slave_active_o) && !$past(takeover_i.parallel_drive)
    |-> second_pin_oe_o == 8'h00)
    else $error("port data beats parallel port");
  a_psp_drive: assert property (
    !$past(rst_i) && $past(parallel_slave_active_o) && $past(takeover_i.parallel_drive)
    |-> second_pin_o == $past(takeover_i.parallel_out) && second_pin_oe_o == 8'hFF)
    else $error("parallel data not on pins");
endmodule : port_checker
`default_nettype wire

// ### tb/pin_partner.sv
// partner: board pins with outside drivers and pull-ups
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  // device side
  input wire logic [7:0] out_i,
  input wire logic [7:0] oe_i,
  // board side
  input wire logic [7:0] ext_i,
  input wire logic [7:0] ext_en_i,
  // resolved level
  output logic [7:0] level_o
);
  // device drive first, then board drive, else pull-up
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      level_o[i] = oe_i[i] ? out_i[i] : (ext_en_i[i] ? ext_i[i] : 1'b1);
    end
  end
endmodule : pin_partner
`default_nettype wire

// ### tb/tb_bidir_port_pin_override.sv
// testbench: register access, pin takeover and serial overrides
`timescale 1ns/1ps
`default_nettype none
module tb_bidir_port_pin_override;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0] adr_i = 0, p1, p2, ext1 = 0, ext2 = 8'h03;
  logic [3:0] sel_i = 0;
  logic [31:0] dat_i = 0, dat_o, rd;
  logic ack_o, err_o, got_err, arx, sdat, sclk, xact, pact;
  logic [7:0] f_o, f_oe, s_o, s_oe, lvl;
  port_pkg::serial_side_t serial_i = '0;
  port_pkg::takeover_t takeover_i = {8'hA5, 1'b1, 8'hC3, 1'b1};
  int mismatches = 0, n_checks = 0, cycles = 0;
  logic [7:0] offs [6] = '{8'h10, 8'h14, 8'h04, 8'h08, 8'h18, 8'h1C};
  logic [7:0] rstv [6] = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00};
  bidir_port_pin_override bidir_port_pin_override_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .first_pin_i(p1), .first_pin_o(f_o),
    .first_pin_oe_o(f_oe), .second_pin_i(p2), .second_pin_o(s_o), .second_pin_oe_o(s_oe),
    .serial_i(serial_i), .async_receive_in_o(arx), .sync_serial_data_o(sdat),
    .sync_serial_clock_o(sclk), .takeover_i(takeover_i), .external_bus_active_o(xact),
    .parallel_slave_active_o(pact), .second_port_level_o(lvl));
  pin_partner pin_partner_inst (.out_i(f_o), .oe_i(f_oe), .ext_i(ext1), .ext_en_i(8'hC0),
    .level_o(p1));
  pin_partner pin_partner_inst2 (.out_i(s_o), .oe_i(s_oe), .ext_i(ext2), .ext_en_i(8'h0F),
    .level_o(p2));
  // clock and hang limit
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hF};
    @(posedge clk_i);
    while (!(ack_o || err_o)) @(posedge clk_i);
    rd = dat_o;
    got_err = err_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask : wb
  task automatic settle;
    repeat (6) @(posedge clk_i);
  endtask : settle
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (offs[i])
    begin
      wb(0, offs[i], 0);
      chk("reset value", {24'h0, rstv[i]}, rd);
    end
    $display("test reset values done");
    wb(1, 8'h14, 32'h0F);
    wb(1, 8'h10, 32'h5A);
    settle();
    chk("bus oe", 8'hFF, s_oe);
    chk("bus out", 8'hA5, s_o);
    $display("test bus takeover done");
    wb(1, 8'h18, 32'h80);
    settle();
    chk("bus active", 0, xact);
    chk("port oe", 8'hF0, s_oe);
    chk("port out", 8'h50, s_o & 8'hF0);
    wb(0, 8'h0C, 0);
    chk("port data", 8'h53, rd);
    chk("port level", 8'h53, lvl);
    wb(0, 8'h10, 0);
    chk("latch read", 8'h5A, rd);
    wb(1, 8'h20, 32'hFF);
    chk("unmapped err", 1, got_err);
    wb(0, 8'h14, 0);
    chk("dir kept", 8'h0F, rd);
    $display("test port latch done");
    wb(1, 8'h1C, 32'h10);
    settle();
    chk("psp active", 1, pact);
    chk("psp out", 8'hC3, s_o);
    takeover_i.parallel_drive <= 1'b0;
    settle();
    chk("psp reads", 8'h00, s_oe);
    takeover_i.parallel_drive <= 1'b1;
    wb(1, 8'h18, 32'h0);
    settle();
    chk("psp yields", 0, pact);
    chk("bus wins", 8'hA5, s_o);
    takeover_i.ext_bus_drive <= 1'b0;
    settle();
    chk("bus release", 8'h00, s_oe);
    takeover_i.ext_bus_drive <= 1'b1;
    $display("test priority done");
    wb(1, 8'h04, 32'h40);
    // pin6 out, pin7 left as input for sync use
    wb(1, 8'h08, 32'h80);
    for (int i = 0; i < 4; i++)
    begin
      serial_i <= {1'b1, i[1], i[0], ~i[0], 1'b1, 2'b00};
      ext1 <= {i[0], 7'h0};
      settle();
      chk("pin6 override", i[1] ^ i[0], f_o[6]);
      chk("pin6 oe", 1, f_oe[6]);
      chk("rx route", i[0], i[1] ? sdat : arx);
    end
    wb(1, 8'h08, 32'hC0);
    for (int v = 0; v < 2; v++)
    begin
      ext1 <= {1'b0, v[0], 6'h0};
      settle();
      chk("clock in", v[0], sclk);
    end
    $display("test serial done");
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, 8'h14, 0);
    chk("dir after reset", 8'hFF, rd);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule : tb_bidir_port_pin_override
bind bidir_port_pin_override port_checker port_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .err_o(err_o), .dat_o(dat_o),
  .second_pin_o(second_pin_o), .second_pin_oe_o(second_pin_oe_o), .takeover_i(takeover_i),
  .external_bus_active_o(external_bus_active_o),
  .parallel_slave_active_o(parallel_slave_active_o));
`default_nettype wire
